// ### design/bsel_top.sv
// Boot mode selector for a four-processor module: groups A and BCD.
// Assumes strap pins are static, software on a plain register port.
// What this block does
// - EPROM select high, link select low means 8-bit EPROM boot
// - EPROM select low: link select and pin decide mode
// - EPROM mode drives pin as EPROM select
// - EPROM low, link high, pin high: link port boot
// - Both low, pin high: wait for host
// - Both low, pin low: run external memory
// - Pin driven only in EPROM mode, three-stated in all others
// - Only bus master drives the pin
// - A has own straps; B/C/D share one
// - One instruction per clock, clock runs free
`timescale 1ns/1ps
module bsel_top
  import bsel_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
  input wire logic clock, // Core clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [31:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  output logic irq, // Level interrupt
  input wire logic eprom_boot_sel_a, // Group A EPROM strap
  input wire logic link_boot_sel_a, // Group A link strap
  input wire logic boot_mem_sel_a_i, // Group A pin, input side
  output logic boot_mem_sel_a_o, // Group A pin, output side
  output logic boot_mem_sel_a_oe, // Group A pin, drive enable
  input wire logic eprom_boot_sel_bcd, // Group BCD EPROM strap
  input wire logic link_boot_sel_bcd, // Group BCD link strap
  input wire logic boot_mem_sel_bcd_i, // Group BCD pin, input side
  output logic boot_mem_sel_bcd_o, // Group BCD pin, output side
  output logic boot_mem_sel_bcd_oe, // Group BCD pin, drive enable
  input wire logic [NUM_GRP-1:0] bus_master, // Group holds the bus
  input wire logic [NUM_GRP-1:0] eprom_cs_req, // Loader selects EPROM
  output logic [NUM_GRP-1:0] boot_go, // Pulse: boot starts
  output bsel_mode_e mode_a, // Group A locked mode
  output bsel_mode_e mode_bcd // Group BCD locked mode
);
  // ==========================================================
  // Per-group decode
  logic [NUM_GRP-1:0] e_pin, l_pin, b_pin, locked, go, rsvd, chg;
  bsel_mode_e mode [NUM_GRP];

  assign e_pin = {eprom_boot_sel_bcd, eprom_boot_sel_a};
  assign l_pin = {link_boot_sel_bcd, link_boot_sel_a};
  assign b_pin = {boot_mem_sel_bcd_i, boot_mem_sel_a_i};

  // Every stage runs on the one free-running instruction clock
  generate
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
      bsel_group #(
        .SETTLE_CYC(SETTLE_CYC)
      ) u_grp (
        .clock(clock),
        .rst_n(rst_n),
        .eprom_sel(e_pin[g]),
        .link_sel(l_pin[g]),
        .boot_mem_in(b_pin[g]),
        .mode(mode[g]),
        .locked(locked[g]),
        .boot_go(go[g]),
        .rsvd_evt(rsvd[g]),
        .chg_evt(chg[g])
      );
    end
  endgenerate

  assign mode_a = mode[GRP_A];
  assign mode_bcd = mode[GRP_BCD];
  assign boot_go = go;

  // ==========================================================
  // Boot memory select pin
  logic [NUM_GRP-1:0] cs_n_r, cs_n_nxt, oe;
  logic [1:0] ctrl_r, ctrl_nxt;

  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      oe[g] = locked[g] && mode[g] == MD_EPROM
        && bus_master[g] && ctrl_r[g];
      cs_n_nxt[g] = !(eprom_cs_req[g] && oe[g]);
    end
  end

  assign boot_mem_sel_a_o = cs_n_r[GRP_A];
  assign boot_mem_sel_bcd_o = cs_n_r[GRP_BCD];
  assign boot_mem_sel_a_oe = oe[GRP_A];
  assign boot_mem_sel_bcd_oe = oe[GRP_BCD];

  // ==========================================================
  // Registers and interrupt
  logic [EVT_W-1:0] status_r, status_nxt, mask_r, mask_nxt, evt, clr;
  logic [31:0] rdata_r, rdata_nxt;

  assign evt = {chg, rsvd, go};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  always_comb begin
    clr = (wr && hit(addr, REG_STATUS)) ? wdata[EVT_W-1:0] : '0;
    status_nxt = (status_r & ~clr) | evt;
    mask_nxt = (wr && hit(addr, REG_MASK)) ? wdata[EVT_W-1:0] : mask_r;
    ctrl_nxt = (wr && hit(addr, REG_CTRL)) ? wdata[1:0] : ctrl_r;
    rdata_nxt = '0;
    if (rd) begin
      case (1'b1)
        hit(addr, REG_STATUS): rdata_nxt = 32'(status_r);
        hit(addr, REG_MASK): rdata_nxt = 32'(mask_r);
        hit(addr, REG_MODE): begin
          rdata_nxt[MODE_W-1:0] = mode[GRP_A];
          rdata_nxt[MODE_BCD_LSB +: MODE_W] = mode[GRP_BCD];
        end
        hit(addr, REG_CTRL): rdata_nxt = 32'(ctrl_r);
        hit(addr, REG_IDENT): rdata_nxt = IDENT_VAL;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
      mask_r <= '0;
      ctrl_r <= CTRL_RST;
      rdata_r <= '0;
      cs_n_r <= '1;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      cs_n_r <= cs_n_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq = |(status_r & mask_r);

  // ==========================================================
  // Checks
  AST_OE_EPROM_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    boot_mem_sel_a_oe |-> mode[GRP_A] == MD_EPROM)
    else $error("pin A driven outside EPROM mode");
  AST_OE_MASTER: assert property (@(posedge clock) disable iff (!rst_n)
    boot_mem_sel_bcd_oe |-> bus_master[GRP_BCD])
    else $error("pin BCD driven by non-master");
  AST_CS_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
    oe[GRP_A] && eprom_cs_req[GRP_A] |=> !boot_mem_sel_a_o)
    else $error("EPROM select not asserted");
  AST_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
    rsvd[GRP_A] |=> status_r[ST_RSVD_LSB] ##1 status_r[ST_RSVD_LSB] || $past(wr))
    else $error("reserved flag lost");
  AST_RDATA_LATE: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  COV_EPROM_DRIVE: cover property (@(posedge clock) disable iff (!rst_n) boot_mem_sel_a_oe);
  COV_IRQ: cover property (@(posedge clock) disable iff (!rst_n) irq);
endmodule

// ### design/bsel_pkg.sv
// Shared constants, modes and decode for the boot mode selector.
// Assumes a single 100 MHz core clock; used by bsel_top and bsel_group.
package bsel_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // Cycles from reset release until the strap filter holds a settled value
  localparam int SYNC_LAT_CYC = 4;
  localparam int NUM_GRP = 2;
  localparam int GRP_A = 0;
  localparam int GRP_BCD = 1;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IDENT = 8'h10;
  // Arbitrary identification value
  localparam logic [31:0] IDENT_VAL = 32'h0000_0B5E;
  localparam int EVT_W = 6;
  localparam int ST_GO_LSB = 0;
  localparam int ST_RSVD_LSB = 2;
  localparam int ST_CHG_LSB = 4;
  localparam int MODE_W = 5;
  localparam int MODE_BCD_LSB = 8;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // ==========================================================
  // Boot modes
  typedef enum logic [MODE_W-1:0] {
    MD_UNSET = 5'h00,
    MD_EPROM = 5'h01,
    MD_HOST = 5'h02,
    MD_LINK = 5'h04,
    MD_EXTMEM = 5'h08,
    MD_RSVD = 5'h10
  } bsel_mode_e;

  function automatic bsel_mode_e bsel_decode(input logic e, input logic l, input logic b);
    if (e && !l) begin
      bsel_decode = MD_EPROM;
    end else if (e) begin
      bsel_decode = MD_RSVD;
    end else if (l) begin
      bsel_decode = b ? MD_LINK : MD_RSVD;
    end else begin
      bsel_decode = b ? MD_HOST : MD_EXTMEM;
    end
  endfunction
endpackage

// ### design/bsel_group.sv
// One processor group: strap synchroniser, settle wait and mode lock.
// Assumes straps are static levels from pins; clock is the core clock.
`timescale 1ns/1ps
module bsel_group
  import bsel_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic eprom_sel, // EPROM boot strap pin
  input wire logic link_sel, // Link boot strap pin
  input wire logic boot_mem_in, // Boot memory select pin level
  output bsel_mode_e mode, // Locked boot mode
  output logic locked, // Mode decided
  output logic boot_go, // Pulse: boot starts
  output logic rsvd_evt, // Pulse: reserved strap combination
  output logic chg_evt // High every cycle while strap differs from locked mode
);
  // ==========================================================
  // Synchroniser, three stages per pin
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_DECIDE = 3'h2,
    ST_RUN = 3'h4
  } bsel_st_e;

  logic [2:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      filt_r <= 3'h0;
    end else begin
      s1_r <= {eprom_sel, link_sel, boot_mem_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    end
  end

  // ==========================================================
  // Decode after reset release
  bsel_st_e st_r, st_nxt;
  bsel_mode_e mode_r, mode_nxt, cur_mode;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  // A short settle time must not decide on the reset value of the filter
  localparam int WAIT_CYC = (SETTLE_CYC > SYNC_LAT_CYC) ? SETTLE_CYC : SYNC_LAT_CYC;
  logic go_nxt, rsvd_nxt, chg_nxt, go_r, rsvd_r, chg_r;

  assign cur_mode = bsel_decode(filt_r[2], filt_r[1], filt_r[0]);

  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    go_nxt = 1'b0;
    rsvd_nxt = 1'b0;
    chg_nxt = 1'b0;
    case (st_r)
      ST_SETTLE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WAIT_CYC - 1)) begin
          st_nxt = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        mode_nxt = cur_mode;
        st_nxt = ST_RUN;
        rsvd_nxt = (cur_mode == MD_RSVD);
        go_nxt = (cur_mode != MD_RSVD) && (cur_mode != MD_EXTMEM);
      end
      ST_RUN: begin
        chg_nxt = (cur_mode != mode_r) && (mode_r != MD_EPROM || !filt_r[2] || filt_r[1]);
      end
      default: st_nxt = ST_SETTLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_SETTLE;
      mode_r <= MD_UNSET;
      cnt_r <= '0;
      go_r <= 1'b0;
      rsvd_r <= 1'b0;
      chg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      go_r <= go_nxt;
      rsvd_r <= rsvd_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign mode = mode_r;
  assign locked = (st_r == ST_RUN);
  assign boot_go = go_r;
  assign rsvd_evt = rsvd_r;
  assign chg_evt = chg_r;

  // ==========================================================
  // Checks
  AST_MODE_FROZEN: assert property (@(posedge clock) disable iff (!rst_n)
    locked && $past(locked) |-> $stable(mode_r))
    else $error("mode changed after lock");
  AST_GO_NOT_RSVD: assert property (@(posedge clock) disable iff (!rst_n)
    rsvd_r |-> !go_r && mode_r == MD_RSVD)
    else $error("reserved mode started a boot");
  AST_NO_GO_EXT: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(locked) && mode_r == MD_EXTMEM |-> !go_r)
    else $error("external memory mode started a boot");
  AST_EPROM_LOCK: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == ST_DECIDE && filt_r[2] && !filt_r[1] |=> mode_r == MD_EPROM && go_r)
    else $error("EPROM strap not decoded");
  AST_LINK_LOCK: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == ST_DECIDE && filt_r == 3'h3 |=> mode_r == MD_LINK)
    else $error("link strap not decoded");
  AST_HOST_LOCK: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == ST_DECIDE && filt_r == 3'h1 |=> mode_r == MD_HOST)
    else $error("host strap not decoded");
  COV_LOCK: cover property (@(posedge clock) disable iff (!rst_n) $rose(locked));
  COV_RSVD: cover property (@(posedge clock) disable iff (!rst_n) rsvd_r);
  COV_CHG: cover property (@(posedge clock) disable iff (!rst_n) chg_r);
endmodule

// ### verif/bsel_pin_model.sv
// Far-side model of one group: strap wiring and boot memory select pin.
// Assumes strap levels come from the bench and are held between resets.
`timescale 1ns/1ps
module bsel_pin_model (
  input wire logic [2:0] cfg, // Strap levels: eprom, link, pin
  input wire logic pin_o, // Block pin output
  input wire logic pin_oe, // Block pin drive enable
  output logic eprom_sel, // EPROM strap
  output logic link_sel, // Link strap
  output logic pin_i // Resolved pin level
);
  assign eprom_sel = cfg[2];
  assign link_sel = cfg[1];
  // A driven pin wins, else the strapped level
  assign pin_i = pin_oe ? pin_o : cfg[0];
endmodule

// ### verif/testbench.sv
// Self-checking bench for the boot mode selector.
// Assumes bsel_pkg, bsel_top and bsel_pin_model are compiled first.
`timescale 1ns/1ps
module testbench;
  import bsel_pkg::*;
  logic clock, rst_n, wr, rd, irq;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] cfg_a, cfg_b;
  logic ea, la, pa_i, pa_o, pa_oe, eb, lb, pb_i, pb_o, pb_oe;
  logic [NUM_GRP-1:0] bus_master, cs_req, boot_go;
  bsel_mode_e mode_a, mode_bcd;
  int n_mismatch, n_compared;
  localparam logic [2:0] CMB [6] = '{3'b100, 3'b001, 3'b011, 3'b000, 3'b010, 3'b111};
  localparam bsel_mode_e EXP [6] = '{MD_EPROM, MD_HOST, MD_LINK, MD_EXTMEM, MD_RSVD, MD_RSVD};

  bsel_top #(.SETTLE_CYC(2)) u_dut (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .eprom_boot_sel_a(ea), .link_boot_sel_a(la),
    .boot_mem_sel_a_i(pa_i), .boot_mem_sel_a_o(pa_o), .boot_mem_sel_a_oe(pa_oe),
    .eprom_boot_sel_bcd(eb), .link_boot_sel_bcd(lb), .boot_mem_sel_bcd_i(pb_i),
    .boot_mem_sel_bcd_o(pb_o), .boot_mem_sel_bcd_oe(pb_oe), .bus_master(bus_master),
    .eprom_cs_req(cs_req), .boot_go(boot_go), .mode_a(mode_a), .mode_bcd(mode_bcd)
  );
  bsel_pin_model u_pa (.cfg(cfg_a), .pin_o(pa_o), .pin_oe(pa_oe), .eprom_sel(ea),
    .link_sel(la), .pin_i(pa_i));
  bsel_pin_model u_pb (.cfg(cfg_b), .pin_o(pb_o), .pin_oe(pb_oe), .eprom_sel(eb),
    .link_sel(lb), .pin_i(pb_i));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // ==========================================================
  // Scenarios
  task automatic run_combo(input int i, input int j);
    int k;
    int ga;
    int gb;
    logic [31:0] st;
    k = 0;
    ga = 0;
    gb = 0;
    @(posedge clock);
    cfg_a <= CMB[i];
    cfg_b <= CMB[j];
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    while (k < 40 && (mode_a === MD_UNSET || mode_bcd === MD_UNSET)) begin
      tick(1);
      k++;
      ga += (boot_go[0] === 1'b1);
      gb += (boot_go[1] === 1'b1);
    end
    if (k == 40) begin
      n_mismatch++;
      close_out();
    end
    repeat (3) begin
      tick(1);
      ga += (boot_go[0] === 1'b1);
      gb += (boot_go[1] === 1'b1);
    end
    chk(32'(mode_a), 32'(EXP[i]));
    chk(32'(mode_bcd), 32'(EXP[j]));
    chk(32'(ga), 32'(i < 3));
    chk(32'(gb), 32'(j < 3));
    chk({30'h0, pa_oe, pb_oe}, 32'h0);
    rd_reg(REG_STATUS, st);
    chk({28'h0, st[3:0]}, {28'h0, j > 3, i > 3, j < 3, i < 3});
  endtask

  task automatic pin_drive();
    logic [31:0] d;
    run_combo(0, 0);
    @(posedge clock);
    bus_master <= 2'b11;
    tick(1);
    chk({30'h0, pa_oe, pb_oe}, 32'h3);
    @(posedge clock);
    cs_req <= 2'b11;
    tick(1);
    chk({30'h0, pa_o, pb_o}, 32'h0);
    chk({30'h0, pa_i, pb_i}, 32'h0);
    @(posedge clock);
    cs_req <= 2'b00;
    tick(1);
    chk({31'h0, pa_o}, 32'h1);
    wr_reg(REG_CTRL, 32'h0000_0000);
    tick(1);
    chk({30'h0, pa_oe, pb_oe}, 32'h0);
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0003);
    tick(1);
    chk({30'h0, pa_oe, pb_oe}, 32'h3);
    @(posedge clock);
    bus_master <= 2'b10;
    tick(1);
    chk({30'h0, pa_oe, pb_oe}, 32'h1);
  endtask

  task automatic regs();
    logic [31:0] d;
    rd_reg(REG_IDENT, d);
    chk(d, IDENT_VAL);
    rd_reg(8'h20, d);
    chk(d, 32'h0);
    wr_reg(REG_MODE, 32'h0);
    rd_reg(REG_MODE, d);
    chk(d, {19'h0, MD_EPROM, 3'h0, MD_EPROM});
    chk({31'h0, irq}, 32'h0);
    wr_reg(REG_MASK, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(REG_STATUS, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    wr_reg(REG_MASK, 32'h2);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(REG_STATUS, 32'h2);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    rd_reg(REG_STATUS, d);
    chk(d, 32'h0);
  endtask

  // Strap moved after lock: mode stays, change flag set and held while moved
  task automatic strap_move();
    logic [31:0] d;
    @(posedge clock);
    cfg_a <= 3'b000;
    tick(8);
    chk(32'(mode_a), 32'(MD_EPROM));
    rd_reg(REG_STATUS, d);
    chk(d, 32'h0000_0010);
    wr_reg(REG_STATUS, 32'h0000_0010);
    rd_reg(REG_STATUS, d);
    chk(d, 32'h0000_0010);
    @(posedge clock);
    cfg_a <= 3'b100;
    tick(8);
    wr_reg(REG_STATUS, 32'h0000_0010);
    rd_reg(REG_STATUS, d);
    chk(d, 32'h0000_0000);
    chk(32'(mode_a), 32'(MD_EPROM));
  endtask

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    cfg_a = 3'b000;
    cfg_b = 3'b000;
    bus_master = '0;
    cs_req = '0;
    for (int i = 0; i < 6; i++) begin
      run_combo(i, 5 - i);
    end
    pin_drive();
    regs();
    strap_move();
    close_out();
  end
endmodule
